// ==== design/hmc_pkg.sv ====
package hmc_pkg;

    // ------------------------------------------------------------
    // Operations-mode programming
    // ------------------------------------------------------------
    localparam logic [9:0] HMC_MODE_CV_NUM = 10'h03c;
    localparam logic [7:0] HMC_MODE_RESET = 8'h00;
    localparam logic [7:0] HMC_MODE_LAST_VALID = 8'h09;

    // ------------------------------------------------------------
    // Mode value decode: bit 0 selects auto-dim, upper bits the base
    // ------------------------------------------------------------
    localparam int HMC_DIM_BIT = 0;
    localparam logic [2:0] HMC_BASE_AUTOREV = 3'h0;
    localparam logic [2:0] HMC_BASE_FRONT = 3'h1;
    localparam logic [2:0] HMC_BASE_REAR = 3'h2;
    localparam logic [2:0] HMC_BASE_BOTH = 3'h3;
    localparam logic [2:0] HMC_BASE_SWAPPED = 3'h4;

    // ------------------------------------------------------------
    // Lamp drive levels
    // ------------------------------------------------------------
    localparam logic [1:0] HMC_LAMP_OFF = 2'h0;
    localparam logic [1:0] HMC_LAMP_DIM = 2'h1;
    localparam logic [1:0] HMC_LAMP_FULL = 2'h2;

    localparam logic [7:0] HMC_SPEED_STOP = 8'h00;

    // ------------------------------------------------------------
    // Start-up sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        HMC_ST_LOAD = 2'b01,
        HMC_ST_RUN = 2'b10
    } hmc_state_t;

endpackage

// ==== design/hmc_headlight_ctrl.sv ====
// Operation
// - Mode 0: front lamp on while direction forward, off in reverse.
// - Autoreverse: rear lamp opposite to front, on in reverse.
// - Lit front lamp runs full brightness with its effect enabled.
// - Auto-dim variants dim the lamp whenever throttle speed is zero.
// - Dimmed lamp runs at reduced level with effect suppressed.
// - Speed above zero restores full brightness and the effect.
// - Modes 2,3 keep front lamp on; 3 adds auto-dim.
// - Modes 4,5 keep rear lamp on; 5 adds auto-dim.
// - Modes 6,7 keep both lamps on; 7 adds auto-dim.
// - Modes 8,9 autoreverse with roles swapped; 9 adds auto-dim.
// - New mode value takes effect at once, no restart.
// - Mode value steers only the front and rear lamp outputs.
// - Each key-0 command toggles the headlight enable.
// - After power-up all lamps and effects are off until commanded.
module hmc_headlight_ctrl
    import hmc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Throttle state
    input wire logic direction_fwd_i,
    input wire logic [7:0] speed_i,
    input wire logic headlight_toggle_key_i,
    // Operations-mode programming
    input wire logic cv_write_i,
    input wire logic [9:0] cv_number_i,
    input wire logic [7:0] cv_data_i,
    // Non-volatile store
    input wire logic [7:0] nv_mode_i,
    output logic nv_write_o,
    output logic [7:0] nv_data_o,
    // Lamp drivers
    output logic [1:0] front_lamp_o,
    output logic front_effect_en_o,
    output logic [1:0] rear_lamp_o,
    output logic rear_effect_en_o,
    // Status
    output logic [7:0] headlight_mode_select_o,
    output logic headlight_enable_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    hmc_state_t state_r;
    hmc_state_t state_nxt;
    logic [7:0] mode_r;
    logic [7:0] mode_nxt;
    logic en_r;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic mode_wr = cv_write_i && (cv_number_i == HMC_MODE_CV_NUM);
    wire logic mode_valid = (mode_r <= HMC_MODE_LAST_VALID);
    wire logic [7:0] eff_mode = mode_valid ? mode_r : HMC_MODE_RESET;
    wire logic auto_dim_option = eff_mode[HMC_DIM_BIT];
    wire logic [2:0] base = eff_mode[3:1];
    wire logic at_stop = (speed_i == HMC_SPEED_STOP);
    wire logic dim_now = auto_dim_option && at_stop;

    wire logic front_sel =
        ((base == HMC_BASE_AUTOREV) && direction_fwd_i) ||
        ((base == HMC_BASE_SWAPPED) && !direction_fwd_i) ||
        (base == HMC_BASE_FRONT) || (base == HMC_BASE_BOTH);
    wire logic rear_sel =
        ((base == HMC_BASE_AUTOREV) && !direction_fwd_i) ||
        ((base == HMC_BASE_SWAPPED) && direction_fwd_i) ||
        (base == HMC_BASE_REAR) || (base == HMC_BASE_BOTH);

    wire logic front_lit = en_r && front_sel;
    wire logic rear_lit = en_r && rear_sel;
    wire logic [1:0] front_lvl = !front_lit ? HMC_LAMP_OFF :
                                 (dim_now ? HMC_LAMP_DIM : HMC_LAMP_FULL);
    wire logic [1:0] rear_lvl = !rear_lit ? HMC_LAMP_OFF :
                                (dim_now ? HMC_LAMP_DIM : HMC_LAMP_FULL);

    // ------------------------------------------------------------
    // Start-up: reload stored mode once after reset release
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        mode_nxt = mode_r;
        case (state_r)
            HMC_ST_LOAD:
            begin
                mode_nxt = mode_wr ? cv_data_i : nv_mode_i;
                state_nxt = HMC_ST_RUN;
            end
            HMC_ST_RUN:
            begin
                if (mode_wr)
                begin
                    mode_nxt = cv_data_i;
                end
            end
            default:
            begin
                state_nxt = HMC_ST_LOAD;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_r <= HMC_ST_LOAD;
            mode_r <= HMC_MODE_RESET;
            en_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            mode_r <= mode_nxt;
            if (headlight_toggle_key_i)
            begin
                en_r <= !en_r;
            end
        end
    end

    // ------------------------------------------------------------
    // Registered outputs: the two headlight channels and the store write
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            front_lamp_o <= HMC_LAMP_OFF;
            rear_lamp_o <= HMC_LAMP_OFF;
            front_effect_en_o <= 1'b0;
            rear_effect_en_o <= 1'b0;
            nv_write_o <= 1'b0;
            nv_data_o <= HMC_MODE_RESET;
        end
        else
        begin
            front_lamp_o <= front_lvl;
            rear_lamp_o <= rear_lvl;
            front_effect_en_o <= front_lit && !dim_now;
            rear_effect_en_o <= rear_lit && !dim_now;
            nv_write_o <= mode_wr;
            if (mode_wr)
            begin
                nv_data_o <= cv_data_i;
            end
        end
    end

    assign headlight_mode_select_o = mode_r;
    assign headlight_enable_o = en_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_mode_written;
        cv_write_i && (cv_number_i == HMC_MODE_CV_NUM);
    endsequence

    sequence s_mode_stored;
        (mode_r == $past(cv_data_i)) && nv_write_o && (nv_data_o == $past(cv_data_i));
    endsequence

    // A write in the load cycle itself replaces the stored value
    sequence s_reloaded;
        (mode_r == $past(nv_mode_i)) && (state_r == HMC_ST_RUN);
    endsequence

    a_mode_write_store: assert property (s_mode_written |=> s_mode_stored)
        else $error("mode write not stored");
    a_other_cv_ignored: assert property (
        cv_write_i && !mode_wr && (state_r == HMC_ST_RUN) |=>
        (mode_r == $past(mode_r)) && !nv_write_o)
        else $error("write to another number changed the mode");
    a_key_toggle_en: assert property (headlight_toggle_key_i |=> (en_r != $past(en_r)))
        else $error("key did not toggle enable");
    a_dark_when_off: assert property (
        !en_r |=> (front_lamp_o == HMC_LAMP_OFF) && (rear_lamp_o == HMC_LAMP_OFF) &&
        !front_effect_en_o && !rear_effect_en_o)
        else $error("lamp lit while disabled");
    a_autorev_fwd: assert property (
        (eff_mode == 8'h00) && en_r && direction_fwd_i |=>
        (front_lamp_o == HMC_LAMP_FULL) && front_effect_en_o &&
        (rear_lamp_o == HMC_LAMP_OFF))
        else $error("autoreverse forward wrong");
    a_autorev_rev: assert property (
        (eff_mode == 8'h00) && en_r && !direction_fwd_i |=>
        (front_lamp_o == HMC_LAMP_OFF) && (rear_lamp_o == HMC_LAMP_FULL) &&
        rear_effect_en_o)
        else $error("autoreverse reverse wrong");
    a_dim_at_stop: assert property (
        auto_dim_option && at_stop && front_lit |=>
        (front_lamp_o == HMC_LAMP_DIM) && !front_effect_en_o)
        else $error("no dim at zero speed");
    a_rear_dim_stop: assert property (
        auto_dim_option && at_stop && rear_lit |=>
        (rear_lamp_o == HMC_LAMP_DIM) && !rear_effect_en_o)
        else $error("rear lamp not dimmed at zero speed");
    a_dim_both_stop: assert property (
        (eff_mode == 8'h07) && en_r && at_stop |=>
        (front_lamp_o == HMC_LAMP_DIM) && (rear_lamp_o == HMC_LAMP_DIM))
        else $error("both-on auto-dim missing");
    a_full_on_move: assert property (
        (eff_mode == 8'h03) && en_r && !at_stop |=>
        (front_lamp_o == HMC_LAMP_FULL) && front_effect_en_o)
        else $error("no full brightness when moving");
    a_rear_full_move: assert property (
        (eff_mode == 8'h05) && en_r && !at_stop |=>
        (rear_lamp_o == HMC_LAMP_FULL) && rear_effect_en_o &&
        (front_lamp_o == HMC_LAMP_OFF))
        else $error("rear lamp not full when moving");
    a_rear_always: assert property (
        (eff_mode == 8'h04) && en_r |=>
        (rear_lamp_o == HMC_LAMP_FULL) && (front_lamp_o == HMC_LAMP_OFF))
        else $error("rear-always wrong");
    a_both_always: assert property (
        (eff_mode == 8'h06) && en_r |=>
        (rear_lamp_o == HMC_LAMP_FULL) && (front_lamp_o == HMC_LAMP_FULL))
        else $error("both-on wrong");
    a_swapped_fwd: assert property (
        (eff_mode == 8'h08) && en_r && direction_fwd_i |=>
        (rear_lamp_o == HMC_LAMP_FULL) && (front_lamp_o == HMC_LAMP_OFF))
        else $error("swapped autoreverse wrong");
    a_reserved_plain: assert property (
        (mode_r > HMC_MODE_LAST_VALID) && en_r && direction_fwd_i && at_stop |=>
        (front_lamp_o == HMC_LAMP_FULL) && (rear_lamp_o == HMC_LAMP_OFF))
        else $error("reserved mode not plain");
    a_reload_nv: assert property (
        (state_r == HMC_ST_LOAD) && !mode_wr |=> s_reloaded ##1 (state_r == HMC_ST_RUN))
        else $error("stored mode not reloaded");
    a_front_always: assert property (
        (eff_mode == 8'h02) && en_r && !direction_fwd_i |=>
        (front_lamp_o == HMC_LAMP_FULL) && (rear_lamp_o == HMC_LAMP_OFF))
        else $error("front-always wrong");

endmodule

// ==== tb/hmc_throttle_model.sv ====
module hmc_throttle_model
(
    // Clock
    input wire logic clk_i,
    // Throttle state
    output logic direction_fwd_o,
    output logic [7:0] speed_o,
    output logic headlight_toggle_key_o,
    // Programming
    output logic cv_write_o,
    output logic [9:0] cv_number_o,
    output logic [7:0] cv_data_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        direction_fwd_o = 1'b1;
        speed_o = 8'h00;
        headlight_toggle_key_o = 1'b0;
        cv_write_o = 1'b0;
        cv_number_o = 10'h000;
        cv_data_o = 8'h00;
    end

    task automatic set_motion(input logic dir, input logic [7:0] spd);
        @(negedge clk_i);
        direction_fwd_o = dir;
        speed_o = spd;
    endtask

    task automatic press_key();
        @(negedge clk_i);
        headlight_toggle_key_o = 1'b1;
        @(negedge clk_i);
        headlight_toggle_key_o = 1'b0;
    endtask

    // Released lines show the inverse so stale data is never trusted
    task automatic write_cv(input logic [9:0] num, input logic [7:0] data);
        @(negedge clk_i);
        cv_write_o = 1'b1;
        cv_number_o = num;
        cv_data_o = data;
        @(negedge clk_i);
        cv_write_o = 1'b0;
        cv_number_o = ~num;
        cv_data_o = ~data;
    endtask
endmodule

// ==== tb/tb_top.sv ====
module tb_top
    import hmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    `define CHECK(act, exp) \
        compares++; \
        if ((act) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("BAD %0t: got %h want %h", $time, act, exp); \
        end

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] nv_mode = 8'h06;
    logic dir, key, cv_write, nv_write, front_fx, rear_fx, hl_en;
    logic [7:0] speed, cv_data, nv_data, mode_sel;
    logic [9:0] cv_number;
    logic [1:0] front_lamp, rear_lamp;
    logic [7:0] lfsr = 8'h25;
    logic [7:0] cur_mode = 8'h06;
    logic [7:0] m;
    logic cur_en = 1'b0;
    logic cur_dir = 1'b1;
    logic [7:0] cur_spd = 8'h00;
    logic [7:0] cur_nv = 8'h00;
    logic [23:0] notes[$];
    logic [23:0] want;
    logic [23:0] got;
    event look;
    int n_mismatch = 0;
    int compares = 0;

    always #50 clk_i = ~clk_i;

    hmc_throttle_model hmc_throttle_model_i (.clk_i(clk_i), .direction_fwd_o(dir),
        .speed_o(speed), .headlight_toggle_key_o(key), .cv_write_o(cv_write),
        .cv_number_o(cv_number), .cv_data_o(cv_data));

    hmc_headlight_ctrl hmc_headlight_ctrl_i (.clk_i(clk_i), .rst_i(rst_i),
        .direction_fwd_i(dir), .speed_i(speed), .headlight_toggle_key_i(key),
        .cv_write_i(cv_write), .cv_number_i(cv_number), .cv_data_i(cv_data),
        .nv_mode_i(nv_mode), .nv_write_o(nv_write), .nv_data_o(nv_data),
        .front_lamp_o(front_lamp), .front_effect_en_o(front_fx), .rear_lamp_o(rear_lamp),
        .rear_effect_en_o(rear_fx), .headlight_mode_select_o(mode_sel),
        .headlight_enable_o(hl_en));

    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    function automatic logic [5:0] lamps_exp(input logic [7:0] md);
        logic [7:0] v;
        logic dim;
        logic f;
        logic r;
        v = (md > HMC_MODE_LAST_VALID) ? HMC_MODE_RESET : md;
        dim = v[HMC_DIM_BIT] && (cur_spd == HMC_SPEED_STOP);
        case (v[3:1])
            HMC_BASE_FRONT: {f, r} = 2'b10;
            HMC_BASE_REAR: {f, r} = 2'b01;
            HMC_BASE_BOTH: {f, r} = 2'b11;
            HMC_BASE_SWAPPED: {f, r} = {!cur_dir, cur_dir};
            default: {f, r} = {cur_dir, !cur_dir};
        endcase
        f = f && cur_en;
        r = r && cur_en;
        return {f ? (dim ? HMC_LAMP_DIM : HMC_LAMP_FULL) : HMC_LAMP_OFF, f && !dim,
            r ? (dim ? HMC_LAMP_DIM : HMC_LAMP_FULL) : HMC_LAMP_OFF, r && !dim};
    endfunction

    task automatic note(input logic [7:0] lamp_mode, input logic nvw);
        notes.push_back({lamps_exp(lamp_mode), cur_en, cur_mode, nvw, cur_nv});
        -> look;
    endtask

    task automatic settle_note();
        repeat (2) @(negedge clk_i);
        note(cur_mode, 1'b0);
    endtask

    assign got = {front_lamp, front_fx, rear_lamp, rear_fx, hl_en, mode_sel, nv_write, nv_data};

    always @(look)
    begin
        want = notes.pop_front();
        `CHECK(got, want)
    end

    task automatic complete_run();
        // Let the last pending compare run before the verdict
        @(negedge clk_i);
        if (notes.size() != 0)
        begin
            n_mismatch++;
            $display("BAD %0t: %0d notes never compared", $time, notes.size());
        end
        $display("Mismatches %0d of %0d compares", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        settle_note();
        hmc_throttle_model_i.press_key();
        cur_en = 1'b1;
        settle_note();
        for (int i = 0; i < 18; i++)
        begin
            m = (i < 16) ? 8'(i) : lfsr;
            hmc_throttle_model_i.write_cv(HMC_MODE_CV_NUM, m);
            m = cur_mode;
            cur_mode = (i < 16) ? 8'(i) : lfsr;
            cur_nv = cur_mode;
            note(m, 1'b1);
            for (int j = 0; j < 4; j++)
            begin
                lfsr = lfsr_next(lfsr);
                cur_dir = j[0];
                cur_spd = j[1] ? lfsr : 8'h00;
                hmc_throttle_model_i.set_motion(cur_dir, cur_spd);
                settle_note();
            end
        end
        hmc_throttle_model_i.write_cv(10'h03d, ~cur_mode);
        note(cur_mode, 1'b0);
        hmc_throttle_model_i.press_key();
        cur_en = 1'b0;
        settle_note();
        @(negedge clk_i);
        nv_mode = 8'h02;
        rst_i = 1'b1;
        cur_nv = 8'h00;
        @(negedge clk_i);
        rst_i = 1'b0;
        cur_mode = 8'h02;
        settle_note();
        complete_run();
    end
endmodule
